// ### hw/arsh_core.sv
/*
 accumulator back end: 40-bit add/sub with clip and guard flags, traps,
 round, store clipping, write-back and barrel shifter, on an AHB-Lite slave.
 assumes: one AHB-Lite master, single word transfers, the core clock.
*/
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "arsh_map.svh"
module arsh_core (
   input wire logic CLK, // core clock, 25 MHz
   input wire logic ARST_N, // async reset, active low
   input wire logic HSEL, // slave select
   input wire logic [31:0] HADDR, // byte address
   input wire logic [1:0] HTRANS, // transfer type
   input wire logic HWRITE, // write when high
   input wire logic [2:0] HSIZE, // word only
   input wire logic [31:0] HWDATA, // write data
   input wire logic HREADY, // bus ready
   output logic HREADYOUT, // ready except in reset, where the flop clears it low
   output logic HRESP, // always okay
   output logic [31:0] HRDATA, // read data
   output logic TRAP_REQ, // arithmetic warning pulse
   output logic XB_WE, // data-space write strobe
   output logic [15:0] XB_ADDR, // data-space byte address of the word
   output logic [15:0] XB_WDATA // data-space write data
);
   // ==========================================================
   // round and store-clip helpers
   function automatic logic [23:0] rnd24(input logic [39:0] a, input logic en,
                                         input logic conv);
      logic inc;
      inc = en & a[15] & (~conv | (a[14:0] != 15'h0000) | a[16]);
      rnd24 = a[39:16] + {23'h00_0000, inc};
   endfunction
   function automatic logic [15:0] stclip(input logic [23:0] r, input logic sgn,
                                          input logic en);
      stclip = r[15:0];
      if (en && !sgn && r > `ARSH_POS24) stclip = `ARSH_POS16;
      if (en && sgn && r < `ARSH_NEG24) stclip = `ARSH_NEG16;
   endfunction

   // ==========================================================
   // state and working signals
   arsh_pkg::arsh_state_t st_q, st_d;
   logic wr, go, go_arith, tsel, sat_en, w32, conv;
   logic [31:0] cmd;
   arsh_pkg::arsh_op_t opk;
   logic [39:0] acc_t, acc_n, a_in, b_in, res, src, shl, shr;
   logic [40:0] sum;
   logic ovf39, ovf31, guard, gflag, cset, trap;
   logic [23:0] r24;
   logic [15:0] xw;
   logic signed [4:0] amt;
   logic [4:0] lamt;

   // ==========================================================
   // next-state logic
   always_comb begin
      st_d = st_q;
      st_d.trap_pulse = 1'b0;
      st_d.xb_we = 1'b0;
      st_d.hready = 1'b1;
      wr = st_q.dp_valid & st_q.dp_write;
      cmd = HWDATA;
      go = wr && st_q.dp_addr == `ARSH_CMD;
      opk = arsh_pkg::arsh_op_t'(cmd[1:0]);
      go_arith = go && (opk == arsh_pkg::OP_ADD || opk == arsh_pkg::OP_SUB);
      // target and non-target accumulator pick
      tsel = cmd[`ARSH_C_ACC];
      acc_t = tsel ? st_q.acc1 : st_q.acc0;
      acc_n = tsel ? st_q.acc0 : st_q.acc1;
      sat_en = tsel ? st_q.cfg[`ARSH_CF_CLIP1] : st_q.cfg[`ARSH_CF_CLIP0];
      w32 = st_q.cfg[`ARSH_CF_WSEL];
      conv = st_q.cfg[`ARSH_CF_RKIND];
      // adder: complement plus carry for subtract
      a_in = cmd[`ARSH_C_ZERO] ? 40'h00_0000_0000 : acc_t;
      b_in = (opk == arsh_pkg::OP_SUB) ? ~st_q.op : st_q.op;
      sum = {a_in[39], a_in} + {b_in[39], b_in}
            + {40'h00_0000_0000, opk == arsh_pkg::OP_SUB};
      ovf39 = sum[40] ^ sum[39];
      ovf31 = !((&sum[40:31]) || !(|sum[40:31]));
      guard = !((&sum[39:32]) || !(|sum[39:32]));
      gflag = guard && !(sat_en && w32);
      cset = (sat_en && w32) ? ovf31 : ovf39;
      // saturation follows true sign in bit 40
      res = sum[39:0];
      if (sat_en && w32 && ovf31) res = sum[40] ? `ARSH_NEG32 : `ARSH_POS32;
      if (sat_en && !w32 && ovf39) res = sum[40] ? `ARSH_NEG40 : `ARSH_POS40;
      trap = (gflag && st_q.trapen[tsel]) || (!sat_en && ovf39 && st_q.trapen[2]);
      // store rounding path
      r24 = rnd24(acc_t, cmd[`ARSH_C_RND], conv);
      // shifter operand and amount
      amt = $signed(cmd[20:16]);
      lamt = 5'(-amt);
      xw = st_q.op[15:0];
      if (cmd[`ARSH_C_XSRC]) begin
         if (amt >= 0) begin
            src = {{8{xw[15] & ~cmd[`ARSH_C_LOGIC]}}, xw, 16'h0000};
         end else begin
            src = {24'h00_0000, xw};
         end
      end else begin
         src = acc_t;
      end
      shr = cmd[`ARSH_C_LOGIC] ? src >> amt[3:0] : 40'($signed(src) >>> amt[3:0]);
      shl = src << lamt;
      // bus address phase capture
      if (HREADY) begin
         st_d.dp_valid = HSEL & HTRANS[1];
         st_d.dp_write = HWRITE;
         st_d.dp_addr = HADDR[7:0];
      end
      // plain register writes
      if (wr) begin
         unique case (st_q.dp_addr)
            `ARSH_CFG: st_d.cfg = HWDATA[7:0];
            `ARSH_TRAPEN: st_d.trapen = HWDATA[2:0];
            `ARSH_OPLO: st_d.op[31:0] = HWDATA;
            `ARSH_OPHI: st_d.op[39:32] = HWDATA[7:0];
            `ARSH_WBPTR: st_d.wbptr = HWDATA[15:0];
            default: ;
         endcase
      end
      // software clears sticky bits, hardware set below wins
      if (wr && st_q.dp_addr == `ARSH_STATUS) begin
         st_d.clip = st_q.clip & ~HWDATA[3:2];
         st_d.trap_st = st_q.trap_st & ~HWDATA[`ARSH_ST_TRAP];
      end
      // launched operations
      if (go_arith) begin
         st_d.gov[tsel] = gflag;
         if (cset) st_d.clip[tsel] = 1'b1;
         if (tsel) st_d.acc1 = res;
         else st_d.acc0 = res;
         if (trap) begin
            st_d.trap_pulse = 1'b1;
            st_d.trap_st = 1'b1;
         end
         // mac write-back of the other accumulator, always rounded
         if (cmd[`ARSH_C_WB] && cmd[11:9] == arsh_pkg::K_MAC) begin
            st_d.sdata = stclip(rnd24(acc_n, 1'b1, conv), acc_n[39],
                                st_q.cfg[`ARSH_CF_STCLIP]);
            if (cmd[`ARSH_C_WBIND]) begin
               st_d.xb_we = 1'b1;
               st_d.xb_addr = st_q.wbptr;
               st_d.xb_wdata = st_d.sdata;
               st_d.wbptr = st_q.wbptr + `ARSH_WBSTEP;
            end else begin
               st_d.wbptr = st_d.sdata;
            end
         end
      end
      if (go && opk == arsh_pkg::OP_STORE) begin
         st_d.sdata = stclip(r24, acc_t[39], st_q.cfg[`ARSH_CF_STCLIP]);
         st_d.xb_we = 1'b1;
         st_d.xb_addr = st_q.op[15:0];
         st_d.xb_wdata = st_d.sdata;
      end
      if (go && opk == arsh_pkg::OP_SHIFT) begin
         st_d.sres = (amt >= 0) ? shr : shl;
         if (cmd[`ARSH_C_XSRC]) begin
            st_d.sres = {24'h00_0000, (amt >= 0) ? st_d.sres[31:16] : st_d.sres[15:0]};
         end
      end
      // read data from the next state, so a write just before is seen
      if (HREADY && HSEL && HTRANS[1] && !HWRITE) begin
         unique case (HADDR[7:0])
            `ARSH_CFG: st_d.hrdata = {24'h00_0000, st_d.cfg};
            `ARSH_TRAPEN: st_d.hrdata = {29'h0000_0000, st_d.trapen};
            `ARSH_STATUS: st_d.hrdata = {25'h000_0000, st_d.trap_st, |st_d.clip,
                                         |st_d.gov, st_d.clip, st_d.gov};
            `ARSH_OPLO: st_d.hrdata = st_d.op[31:0];
            `ARSH_OPHI: st_d.hrdata = {24'h00_0000, st_d.op[39:32]};
            `ARSH_ACC0LO: st_d.hrdata = st_d.acc0[31:0];
            `ARSH_ACC0HI: st_d.hrdata = {24'h00_0000, st_d.acc0[39:32]};
            `ARSH_ACC1LO: st_d.hrdata = st_d.acc1[31:0];
            `ARSH_ACC1HI: st_d.hrdata = {24'h00_0000, st_d.acc1[39:32]};
            `ARSH_WBPTR: st_d.hrdata = {16'h0000, st_d.wbptr};
            `ARSH_SDATA: st_d.hrdata = {16'h0000, st_d.sdata};
            `ARSH_SRESLO: st_d.hrdata = st_d.sres[31:0];
            `ARSH_SRESHI: st_d.hrdata = {24'h00_0000, st_d.sres[39:32]};
            default: st_d.hrdata = 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // outputs straight from flops, HRESP tied low
   assign HREADYOUT = st_q.hready;
   assign HRESP = 1'b0;
   assign HRDATA = st_q.hrdata;
   assign TRAP_REQ = st_q.trap_pulse;
   assign XB_WE = st_q.xb_we;
   assign XB_ADDR = st_q.xb_addr;
   assign XB_WDATA = st_q.xb_wdata;

   // ==========================================================
   // checks
   AST_GUARD: assert property (@(posedge CLK) disable iff (!ARST_N)
      go_arith && !tsel |=> st_q.gov[0] == $past(guard && !(sat_en && w32)))
      else $error("guard flag wrong");
   AST_TRAP: assert property (@(posedge CLK) disable iff (!ARST_N)
      go_arith && gflag && st_q.trapen[tsel] |=> TRAP_REQ && st_q.trap_st)
      else $error("guard trap missing");
   AST_CLIP_STICKY: assert property (@(posedge CLK) disable iff (!ARST_N)
      st_q.clip[0] && !(wr && st_q.dp_addr == `ARSH_STATUS) |=> st_q.clip[0])
      else $error("clip flag lost");
   AST_EITHER: assert property (@(posedge CLK) disable iff (!ARST_N)
      HREADY && HSEL && HTRANS[1] && !HWRITE && HADDR[7:0] == `ARSH_STATUS
      |=> HRDATA[`ARSH_ST_EGOV] == (|st_q.gov) && HRDATA[`ARSH_ST_ECLIP] == (|st_q.clip))
      else $error("combined status wrong");
   AST_SAT40: assert property (@(posedge CLK) disable iff (!ARST_N)
      go_arith && !tsel && sat_en && !w32 && ovf39 && !sum[40]
      |=> st_q.acc0 == `ARSH_POS40 && st_q.clip[0])
      else $error("40-bit clip wrong");
   AST_SAT32: assert property (@(posedge CLK) disable iff (!ARST_N)
      go_arith && tsel && sat_en && w32 && ovf31 && sum[40]
      |=> st_q.acc1 == `ARSH_NEG32 && !st_q.gov[1])
      else $error("32-bit clip wrong");
   AST_WRAP: assert property (@(posedge CLK) disable iff (!ARST_N)
      go_arith && !tsel && !sat_en && ovf39 && st_q.trapen[2]
      |=> st_q.acc0 == $past(sum[39:0]) && st_q.clip[0] && TRAP_REQ)
      else $error("wrap overflow wrong");
   AST_WB_INC: assert property (@(posedge CLK) disable iff (!ARST_N)
      go_arith && cmd[`ARSH_C_WB] && cmd[`ARSH_C_WBIND] && cmd[11:9] == 3'h0
      |=> XB_WE && XB_ADDR == $past(st_q.wbptr) && st_q.wbptr == $past(st_q.wbptr) + 16'h0002)
      else $error("write-back pointer wrong");
   AST_CONV_TIE: assert property (@(posedge CLK) disable iff (!ARST_N)
      go && opk == arsh_pkg::OP_STORE && cmd[`ARSH_C_RND] && conv && !acc_t[16]
      && acc_t[15:0] == `ARSH_HALF && !st_q.cfg[`ARSH_CF_STCLIP]
      |=> XB_WDATA == $past(acc_t[31:16]))
      else $error("convergent tie rounded");
   AST_STCLIP: assert property (@(posedge CLK) disable iff (!ARST_N)
      go && opk == arsh_pkg::OP_STORE && st_q.cfg[`ARSH_CF_STCLIP] && !acc_t[39]
      && r24 > `ARSH_POS24 |=> XB_WDATA == `ARSH_POS16 && st_q.acc0 == $past(st_q.acc0))
      else $error("store clip wrong");
   AST_SHIFT0: assert property (@(posedge CLK) disable iff (!ARST_N)
      go && opk == arsh_pkg::OP_SHIFT && !cmd[`ARSH_C_XSRC] && amt == 5'sd0
      |=> st_q.sres == $past(acc_t))
      else $error("zero shift changed operand");
endmodule // arsh_core
`default_nettype wire

// ### hw/arsh_map.svh
/*
 accumulator back end: register offsets, field positions, reset values.
 assumes: included by the package and the design module.
*/
`ifndef ARSH_MAP_SVH
`define ARSH_MAP_SVH
// ==========================================================
// register byte offsets
`define ARSH_CFG 8'h00
`define ARSH_TRAPEN 8'h04
`define ARSH_STATUS 8'h08
`define ARSH_OPLO 8'h0C
`define ARSH_OPHI 8'h10
`define ARSH_CMD 8'h14
`define ARSH_ACC0LO 8'h18
`define ARSH_ACC0HI 8'h1C
`define ARSH_ACC1LO 8'h20
`define ARSH_ACC1HI 8'h24
`define ARSH_WBPTR 8'h28
`define ARSH_SDATA 8'h2C
`define ARSH_SRESLO 8'h30
`define ARSH_SRESHI 8'h34
// ==========================================================
// core config bits
`define ARSH_CF_CLIP0 7
`define ARSH_CF_CLIP1 6
`define ARSH_CF_WSEL 4
`define ARSH_CF_RKIND 1
`define ARSH_CF_STCLIP 0
// status bits
`define ARSH_ST_EGOV 4
`define ARSH_ST_ECLIP 5
`define ARSH_ST_TRAP 6
// command fields
`define ARSH_C_ACC 2
`define ARSH_C_ZERO 3
`define ARSH_C_WB 4
`define ARSH_C_WBIND 5
`define ARSH_C_RND 6
`define ARSH_C_XSRC 7
`define ARSH_C_LOGIC 8
// ==========================================================
// reset values and limits
`define ARSH_CFG_RST 8'h00
`define ARSH_WBPTR_RST 16'h0000
`define ARSH_POS40 40'h7F_FFFF_FFFF
`define ARSH_NEG40 40'h80_0000_0000
`define ARSH_POS32 40'h00_7FFF_FFFF
`define ARSH_NEG32 40'hFF_8000_0000
`define ARSH_POS24 24'h00_7FFF
`define ARSH_NEG24 24'hFF_8000
`define ARSH_POS16 16'h7FFF
`define ARSH_NEG16 16'h8000
`define ARSH_HALF 16'h8000
`define ARSH_WBSTEP 16'h0002
`endif

// ### hw/arsh_pkg.sv
/*
 accumulator back end: types and the packed state record.
 assumes: nothing beyond the map header.
*/
`include "arsh_map.svh"
package arsh_pkg;
   // ==========================================================
   // command kinds
   typedef enum logic [1:0] {OP_ADD, OP_SUB, OP_STORE, OP_SHIFT} arsh_op_t;
   typedef enum logic [2:0] {K_MAC, K_MPY, K_MPYN, K_ED, K_DIFF_SQUARE_ACCUM_OP} arsh_kind_t;
   // ==========================================================
   // whole module state
   typedef struct packed {
      logic [7:0] cfg;
      logic [2:0] trapen;
      logic [1:0] gov;
      logic [1:0] clip;
      logic trap_st;
      logic [39:0] op;
      logic [15:0] wbptr;
      logic [39:0] sres;
      logic [15:0] sdata;
      logic [39:0] acc0;
      logic [39:0] acc1;
      logic dp_valid;
      logic dp_write;
      logic [7:0] dp_addr;
      logic [31:0] hrdata;
      logic hready;
      logic trap_pulse;
      logic xb_we;
      logic [15:0] xb_addr;
      logic [15:0] xb_wdata;
   } arsh_state_t;
endpackage

// ### sim/arsh_xmem.sv
/*
 data-space memory on the X write bus, far side of the back end.
 assumes: one word write per XB_WE pulse, core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module arsh_xmem (
   input wire logic CLK, // core clock
   input wire logic ARST_N, // async reset, active low
   input wire logic XB_WE, // write strobe
   input wire logic [15:0] XB_ADDR, // byte address of the word
   input wire logic [15:0] XB_WDATA, // write data
   output logic SEEN, // pulse per write taken
   output logic [31:0] LAST // address and data of last write
);
   // ==========================================================
   // word store and write capture
   logic [15:0] mem_q [0:127];
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         SEEN <= 1'b0;
         LAST <= 32'h0000_0000;
      end else begin
         SEEN <= XB_WE;
         if (XB_WE) begin
            mem_q[XB_ADDR[7:1]] <= XB_WDATA;
            LAST <= {XB_ADDR, XB_WDATA};
         end
      end
   end
endmodule // arsh_xmem
`default_nettype wire

// ### sim/tb_accumulator_saturate_round_shift.sv
/*
 self-checking bench: AHB-Lite master, reference model, note queues.
 assumes: arsh_core, arsh_xmem and the map header.
*/
`timescale 1ns/1ps
`default_nettype none
`include "arsh_map.svh"
module tb_accumulator_saturate_round_shift;
   // ==========================================================
   // signals and model state
   logic clk, arst_n, hsel, hwrite, hreadyout, hresp, trap_req, xb_we, seen;
   logic [31:0] haddr, hwdata, hrdata, last, rv, rw, xe;
   logic [1:0] htrans, mg, mc;
   logic [2:0] hsize, ten, kd;
   logic [15:0] xb_addr, xb_wdata, mptr;
   logic [39:0] ma [2];
   logic [39:0] tbl [4];
   logic [39:0] v, re;
   logic [7:0] cfg;
   logic [4:0] sn;
   logic mt;
   logic dp_rd = 1'b0;
   logic [39:0] rdq [$];
   logic [31:0] xbq [$];
   int fails = 0;
   int n_compared = 0;
   int cyc = 0;
   int tq = 0;
   arsh_core i_arsh_core (.CLK(clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
      .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata),
      .TRAP_REQ(trap_req), .XB_WE(xb_we), .XB_ADDR(xb_addr), .XB_WDATA(xb_wdata));
   arsh_xmem i_arsh_xmem (.CLK(clk), .ARST_N(arst_n), .XB_WE(xb_we),
      .XB_ADDR(xb_addr), .XB_WDATA(xb_wdata), .SEEN(seen), .LAST(last));
   // clock, 40 ns
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ==========================================================
   // compare, verdict, bus cycles
   task automatic chk(input string nm, input logic [39:0] sv, input logic [39:0] ev);
      n_compared++;
      if (sv !== ev) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, ev, sv);
      end
   endtask
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                      input logic [31:0] e);
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      if (!w) rdq.push_back({a, e});
      do @(posedge clk); while (hreadyout !== 1'b1);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d, 32'h0000_0000);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(a, 1'b0, 32'h0000_0000, e);
   endtask
   // ==========================================================
   // reference model
   function automatic logic [31:0] xs();
      rv = rv ^ (rv << 13);
      rv = rv ^ (rv >> 17);
      rv = rv ^ (rv << 5);
      return rv;
   endfunction
   function automatic logic [31:0] sts();
      return {25'h000_0000, mt, |mc, |mg, mc, mg};
   endfunction
   function automatic logic [15:0] stv(input logic [39:0] a, input logic r);
      logic inc;
      logic [23:0] t;
      inc = r && (a[15:0] > 16'h8000 || (a[15:0] == 16'h8000 && (!cfg[1] || a[16])));
      t = a[39:16] + {23'h00_0000, inc};
      if (cfg[0] && !a[39] && t > 24'h00_7FFF) return 16'h7FFF;
      if (cfg[0] && a[39] && t < 24'hFF_8000) return 16'h8000;
      return t[15:0];
   endfunction
   task automatic alu(input logic s, input logic sub, input logic z, input logic [39:0] o,
                      input logic [31:0] x);
      logic [40:0] sum;
      logic sat, o39, o31, g;
      logic [39:0] r;
      wr(`ARSH_OPLO, o[31:0]);
      wr(`ARSH_OPHI, {24'h00_0000, o[39:32]});
      if (x[4] && x[11:9] == 3'h0) begin
         xe = {mptr, stv(ma[!s], 1'b1)};
         if (x[5]) xbq.push_back(xe);
         mptr = x[5] ? mptr + 16'h0002 : xe[15:0];
      end
      sum = (z ? 41'h000_0000_0000 : {ma[s][39], ma[s]}) + (sub ? -{o[39], o} : {o[39], o});
      sat = cfg[s ? 6 : 7];
      o39 = sum[40] ^ sum[39];
      o31 = sum[40:31] != {10{sum[40]}};
      r = sum[39:0];
      if (sat && cfg[4] && o31) r = sum[40] ? `ARSH_NEG32 : `ARSH_POS32;
      if (sat && !cfg[4] && o39) r = sum[40] ? `ARSH_NEG40 : `ARSH_POS40;
      g = !(sat && cfg[4]) && sum[39:32] != 8'h00 && sum[39:32] != 8'hFF;
      mc[s] = mc[s] | ((sat && cfg[4]) ? o31 : o39);
      if ((g && ten[s]) || (!sat && o39 && ten[2])) tq++;
      mt = mt | (g && ten[s]) | (!sat && o39 && ten[2]);
      ma[s] = r;
      mg[s] = g;
      wr(`ARSH_CMD, x | {28'h000_0000, z, s, 1'b0, sub});
      rd(s ? `ARSH_ACC1LO : `ARSH_ACC0LO, r[31:0]);
      rd(s ? `ARSH_ACC1HI : `ARSH_ACC0HI, {24'h00_0000, r[39:32]});
      rd(`ARSH_STATUS, sts());
   endtask
   task automatic store(input logic s, input logic r, input logic [15:0] ad);
      xe = {ad, stv(ma[s], r)};
      wr(`ARSH_OPLO, {16'h0000, ad});
      xbq.push_back(xe);
      wr(`ARSH_CMD, {25'h000_0000, r, 3'h0, s, 2'b10});
      rd(`ARSH_SDATA, {16'h0000, xe[15:0]});
      rd(s ? `ARSH_ACC1LO : `ARSH_ACC0LO, ma[s][31:0]);
   endtask
   task automatic shift(input logic s, input logic xsrc, input logic lg, input logic [15:0] xd);
      logic [39:0] o, e;
      o = xsrc ? (sn[4] ? {24'h00_0000, xd} : {lg ? 8'h00 : {8{xd[15]}}, xd, 16'h0000}) : ma[s];
      if (sn[4]) e = o << (5'h00 - sn);
      else if (lg) e = o >> sn;
      else e = $signed(o) >>> sn;
      if (xsrc) e = {24'h00_0000, sn[4] ? e[15:0] : e[31:16]};
      wr(`ARSH_OPLO, {16'h0000, xd});
      wr(`ARSH_CMD, {11'h000, sn, 7'h00, lg, xsrc, 4'h0, s, 2'b11});
      rd(`ARSH_SRESLO, e[31:0]);
      rd(`ARSH_SRESHI, {24'h00_0000, e[39:32]});
   endtask
   // ==========================================================
   // output watcher and timeout
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         fails++;
         close_out();
      end
      if (dp_rd) begin
         re = rdq.pop_front();
         chk($sformatf("read %h", re[39:32]), {8'h00, hrdata}, {8'h00, re[31:0]});
      end
      dp_rd <= arst_n && hsel && htrans[1] && !hwrite && hreadyout;
      if (trap_req === 1'b1) tq--;
      if (seen === 1'b1) chk("xbus write", {8'h00, last}, {8'h00, xbq.pop_front()});
   end
   // ==========================================================
   // main sequence
   initial begin
      {arst_n, hsel, hwrite, htrans, mg, mc, mt, cfg, ten} = '0;
      {haddr, hwdata, mptr} = '0;
      hsize = 3'b010;
      rv = 32'h0000_bea0;
      ma = '{40'h00_0000_0000, 40'h00_0000_0000};
      tbl = '{40'h00_1234_8000, 40'h00_1235_8000, 40'h00_7FFF_8001, 40'hFF_7FFF_7FFF};
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      hsel <= 1'b1;
      @(posedge clk);
      rd(`ARSH_CFG, {24'h00_0000, `ARSH_CFG_RST});
      rd(`ARSH_WBPTR, {16'h0000, `ARSH_WBPTR_RST});
      rd(`ARSH_STATUS, 32'h0000_0000);
      wr(8'hFC, 32'hFFFF_FFFF);
      rd(8'hFC, 32'h0000_0000);
      ten = 3'b011;
      wr(`ARSH_TRAPEN, {29'h0000_0000, ten});
      alu(1'b0, 1'b0, 1'b1, 40'h00_FFFF_FFFF, 32'h0000_0000);
      alu(1'b0, 1'b0, 1'b0, 40'h00_0000_0001, 32'h0000_0000);
      alu(1'b1, 1'b1, 1'b1, 40'h00_0000_0001, 32'h0000_0000);
      // wrap, 40-bit and 32-bit saturation with random operands
      for (int m = 0; m < 3; m++) begin
         cfg = (m == 0) ? 8'h00 : (m == 1) ? 8'hC0 : 8'hD0;
         ten = 3'(xs());
         wr(`ARSH_CFG, {24'h00_0000, cfg});
         wr(`ARSH_TRAPEN, {29'h0000_0000, ten});
         wr(`ARSH_STATUS, 32'h0000_004C);
         mc = 2'b00;
         mt = 1'b0;
         rd(`ARSH_STATUS, sts());
         for (int i = 0; i < 14; i++) begin
            rw = xs();
            v = rv[0] ? {{8{rw[31]}}, rw} : {rv[15:8], rw};
            alu(rv[1], rv[2], rv[3] && rv[4], v, 32'h0000_0000);
         end
      end
      // truncated and rounded stores in every round and clip setting
      for (int k = 0; k < 32; k++) begin
         cfg = {6'h00, k[1], k[0]};
         wr(`ARSH_CFG, {24'h00_0000, cfg});
         alu(k[2] ^ k[3], 1'b0, 1'b1, tbl[k[4:3]], 32'h0000_0000);
         store(k[2] ^ k[3], k[2], 16'h0100 + 16'(2 * k));
      end
      // write-back in both modes over every mac kind
      wr(`ARSH_WBPTR, 32'h0000_0200);
      mptr = 16'h0200;
      for (int k = 0; k < 10; k++) begin
         kd = 3'(k % 5);
         alu(k[0], 1'b0, 1'b0, 40'h00_0000_0100, {20'h0_0000, kd, 3'h0, k >= 5, 1'b1, 4'h0});
         rd(`ARSH_WBPTR, {16'h0000, mptr});
      end
      // barrel shifter, boundary amounts first
      for (int i = 0; i < 16; i++) begin
         rw = xs();
         sn = (i == 0) ? 5'h00 : (i == 1) ? 5'h10 : (i == 2) ? 5'h0F : rw[12:8];
         shift(rw[0], rw[1], rw[2], rw[31:16]);
      end
      repeat (4) @(posedge clk);
      chk("trap count", 40'(tq), 40'h00_0000_0000);
      chk("xbus notes", 40'(xbq.size()), 40'h00_0000_0000);
      close_out();
   end
endmodule // tb_accumulator_saturate_round_shift
`default_nettype wire
